// ===== hdl/dbis_defines.svh
// widths, field positions and timing constants for the drum block-input sequencer
`ifndef DBIS_DEFINES_SVH
`define DBIS_DEFINES_SVH

// clock
`define DBIS_CLK_PERIOD_NS 20
`define DBIS_CYC_PER_US (1000 / `DBIS_CLK_PERIOD_NS)

// widths and fifo depth
`define DBIS_WORD_W 16
`define DBIS_ADDR_W 11
`define DBIS_CNT_W 11
`define DBIS_US_W 6
`define DBIS_SI_W 9
`define DBIS_FIFO_DEPTH 4

// stop-clock and time-pulse spacings, microseconds
`define DBIS_T_STEP_US 6'h01
`define DBIS_T_CARRY_US 6'h02
`define DBIS_T_CARRY_FAST_US 6'h01
`define DBIS_T_ES_WRITE_US 6'h25
`define DBIS_T_ES_READ_US 6'h11

// select-device codes: upper six bits 70 octal pick the drum
`define DBIS_SI_DRUM_HI 6'h38
`define DBIS_SI_RECORD_BIT 2
`define DBIS_SI_GROUP_BIT 1
`define DBIS_SI_POS_BIT 0

`endif

// ===== hdl/dbis_pkg.sv
// types shared by the drum block-input sequencer files
`include "dbis_defines.svh"

package dbis_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TP6, ST_TP7, ST_TP8, ST_TP1, ST_TP2, ST_TP3, ST_TP4, ST_TP5
  } dbis_state_t;

  typedef struct packed {
    logic [`DBIS_ADDR_W-1:0] addr;
    logic [`DBIS_WORD_W-1:0] data;
  } dbis_es_write_t;

  typedef struct packed {
    logic prep_read;
    logic prep_record;
    logic chg_group;
    logic chg_pos;
    logic addr_reset;
  } dbis_si_t;

endpackage

// ===== hdl/dbis_us_timer.sv
// stop-clock delay timer counting whole microseconds from a cycle divider
`timescale 1ns/1ps
`default_nettype none
`include "dbis_defines.svh"

module dbis_us_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [`DBIS_US_W-1:0] us,
  output logic done
);

  localparam logic [`DBIS_US_W-1:0] CYC_LAST = `DBIS_US_W'(`DBIS_CYC_PER_US - 1);

  logic [`DBIS_US_W-1:0] cyc_q;
  logic [`DBIS_US_W-1:0] us_q;
  wire logic us_tick;

  // divider restarts on load so every delay is exact to the cycle
  assign us_tick = (cyc_q == CYC_LAST);
  assign done = (us_q == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
      us_q <= '0;
    end else if (load) begin
      cyc_q <= '0;
      us_q <= us;
    end else if (!done) begin
      cyc_q <= us_tick ? '0 : cyc_q + 1'b1;
      us_q <= us_tick ? us_q - 1'b1 : us_q;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/dbis_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dbis_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire logic push;
  wire logic pop;

  assign in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
      rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// ===== hdl/dbis_block_input.sv
// drum block-input sequencer: time-pulse sequencing, drum handshake and select-device decode
//
// What this block does
// - End-carry seen at time pulse two ends the order; accumulator ends one past last.
// - First word absent at time pulse six: halt while the started storage read finishes.
// - Read done, word still absent: everything stays halted until the word arrives.
// - Time pulse seven follows a word arrival within 3 microseconds.
// - First cycle: stop delays at pulses seven, eight and one put 5 microseconds from pulse seven to two.
// - Pulse two requests the next word when more remain; drum must get it promptly.
// - Storage write at pulse two holds pulse three 37 us; pulse four 1 us later.
// - Pulse four read stops 17 us; restart only when read and word both complete.
// - Later cycles: 3 microseconds from pulse five to the next pulse two.
// - Word arriving during the pulse-four read costs no extra synchronising delay.
// - n cycles must fit within 64n + 37 microseconds to catch every word.
// - Decode select codes 700..707 octal: upper four record, lower four read.
// - Low code bit changes position, next bit changes group, both change both.
// - Restoration only at suitable points; end-carry wait may be shortened.
// - Pulse one increments the word counter and stops 2 us for an end-carry.
// - Pulse-two request sets the word interlock and clears alarm; arrival clears interlock.
// - Read preparation with position change resets the drum address register.
`timescale 1ns/1ps
`default_nettype none
`include "dbis_defines.svh"

module dbis_block_input (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic START,
  input wire logic [`DBIS_ADDR_W-1:0] START_ADDR,
  input wire logic [`DBIS_CNT_W-1:0] BLOCK_COUNT,
  input wire logic FAST_CARRY,
  input wire logic SI_STROBE,
  input wire logic [`DBIS_SI_W-1:0] SI_CODE,
  input wire logic WORD_ARRIVED,
  input wire logic [`DBIS_WORD_W-1:0] DRUM_WORD,
  output logic REQUEST_NEXT_WORD,
  output logic PREP_READ,
  output logic PREP_RECORD,
  output logic CHANGE_GROUP,
  output logic CHANGE_POSITION,
  output logic DRUM_ADDR_RESET,
  output logic ES_WR_VALID,
  input wire logic ES_WR_READY,
  output logic [`DBIS_ADDR_W-1:0] ES_WR_ADDR,
  output logic [`DBIS_WORD_W-1:0] ES_WR_DATA,
  output logic BUSY,
  output logic DONE,
  output logic [`DBIS_ADDR_W-1:0] ACC,
  output logic [3:0] TIME_PULSE,
  output logic CLOCK_STOPPED,
  output logic ALARM,
  output logic RESTORE_OK
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and word-arrival synchroniser

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic arr_meta_q;
  logic arr_sync_q;
  logic arr_last_q;
  wire logic arrive;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      arr_meta_q <= 1'b0;
      arr_sync_q <= 1'b0;
      arr_last_q <= 1'b0;
    end else begin
      arr_meta_q <= WORD_ARRIVED;
      arr_sync_q <= arr_meta_q;
      arr_last_q <= arr_sync_q;
    end
  end

  assign arrive = arr_sync_q && !arr_last_q;

  ////////////////////////////////////////////////////////////////////////////
  // select-device decode

  wire logic si_drum;
  wire logic si_rec;
  dbis_pkg::dbis_si_t si_d;
  dbis_pkg::dbis_si_t si_q;

  assign si_drum = SI_STROBE && (SI_CODE[`DBIS_SI_W-1:3] == `DBIS_SI_DRUM_HI);
  assign si_rec = SI_CODE[`DBIS_SI_RECORD_BIT];
  assign si_d.prep_read = si_drum && !si_rec;
  assign si_d.prep_record = si_drum && si_rec;
  assign si_d.chg_group = si_drum && SI_CODE[`DBIS_SI_GROUP_BIT];
  assign si_d.chg_pos = si_drum && SI_CODE[`DBIS_SI_POS_BIT];
  // rereading a skipped word needs the drum address wound back
  assign si_d.addr_reset = si_d.prep_read && SI_CODE[`DBIS_SI_POS_BIT];

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      si_q <= '0;
    end else begin
      si_q <= si_d;
    end
  end

  assign PREP_READ = si_q.prep_read;
  assign PREP_RECORD = si_q.prep_record;
  assign CHANGE_GROUP = si_q.chg_group;
  assign CHANGE_POSITION = si_q.chg_pos;
  assign DRUM_ADDR_RESET = si_q.addr_reset;

  ////////////////////////////////////////////////////////////////////////////
  // time-pulse sequencer

  dbis_pkg::dbis_state_t state_q;
  dbis_pkg::dbis_state_t nxt;
  logic go;
  logic ilock_q;
  logic carry_q;
  logic zero_q;
  logic end_q;
  logic first_q;
  logic [`DBIS_CNT_W-1:0] cnt_q;
  logic [`DBIS_ADDR_W-1:0] acc_q;
  logic [`DBIS_WORD_W-1:0] io_word_register_q;
  logic t_done;
  logic fifo_in_ready;
  wire logic [`DBIS_US_W-1:0] carry_us;

  // a shorter end-carry wait buys back time when restoration crowds a cycle
  assign carry_us = FAST_CARRY ? `DBIS_T_CARRY_FAST_US : `DBIS_T_CARRY_US;

  function automatic logic [`DBIS_US_W-1:0] dwell(input dbis_pkg::dbis_state_t s,
                                                  input logic [`DBIS_US_W-1:0] cw);
    unique case (s)
      dbis_pkg::ST_TP6: dwell = `DBIS_T_ES_READ_US;
      dbis_pkg::ST_TP8: dwell = cw;
      dbis_pkg::ST_TP1: dwell = cw;
      dbis_pkg::ST_TP2: dwell = `DBIS_T_ES_WRITE_US;
      dbis_pkg::ST_TP4: dwell = `DBIS_T_ES_READ_US;
      default: dwell = `DBIS_T_STEP_US;
    endcase
  endfunction

  always_comb begin
    nxt = state_q;
    go = 1'b0;
    unique case (state_q)
      dbis_pkg::ST_IDLE: begin
        if (START) begin
          nxt = dbis_pkg::ST_TP6;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP6: begin
        if (t_done && !ilock_q) begin
          nxt = dbis_pkg::ST_TP7;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP7: begin
        if (t_done) begin
          nxt = dbis_pkg::ST_TP8;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP8: begin
        if (t_done) begin
          nxt = dbis_pkg::ST_TP1;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP1: begin
        if (t_done && zero_q) begin
          nxt = dbis_pkg::ST_IDLE;
          go = 1'b1;
        end else if (t_done && fifo_in_ready) begin
          nxt = dbis_pkg::ST_TP2;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP2: begin
        if (t_done) begin
          nxt = end_q ? dbis_pkg::ST_IDLE : dbis_pkg::ST_TP3;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP3: begin
        if (t_done) begin
          nxt = dbis_pkg::ST_TP4;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP4: begin
        // arrival already synchronised in the background during the read
        if (t_done && !ilock_q) begin
          nxt = dbis_pkg::ST_TP5;
          go = 1'b1;
        end
      end
      dbis_pkg::ST_TP5: begin
        if (t_done) begin
          nxt = dbis_pkg::ST_TP1;
          go = 1'b1;
        end
      end
    endcase
  end

  wire logic add_one;
  wire logic at_tp1;
  wire logic at_tp2;
  wire logic finish;
  wire logic [`DBIS_CNT_W:0] cnt_sum;

  assign add_one = go && (nxt == dbis_pkg::ST_TP8 || nxt == dbis_pkg::ST_TP1);
  assign at_tp1 = go && (nxt == dbis_pkg::ST_TP1);
  assign at_tp2 = go && (nxt == dbis_pkg::ST_TP2);
  assign finish = go && (nxt == dbis_pkg::ST_IDLE);
  assign cnt_sum = {1'b0, cnt_q} + 1'b1;

  dbis_us_timer u_timer (
    .clk(CLK),
    .rst_n(rst_n_q),
    .load(go && nxt != dbis_pkg::ST_IDLE),
    .us(dwell(nxt, carry_us)),
    .done(t_done)
  );

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= dbis_pkg::ST_IDLE;
      first_q <= 1'b0;
      zero_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      state_q <= nxt;
      first_q <= (go && state_q == dbis_pkg::ST_IDLE) || (first_q && !at_tp2);
      zero_q <= at_tp1 ? (first_q && carry_q) : zero_q;
      end_q <= at_tp2 ? carry_q : end_q;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= '0;
      carry_q <= 1'b0;
      acc_q <= '0;
    end else if (START && state_q == dbis_pkg::ST_IDLE) begin
      cnt_q <= BLOCK_COUNT;
      carry_q <= 1'b0;
      acc_q <= START_ADDR;
    end else begin
      cnt_q <= add_one ? cnt_sum[`DBIS_CNT_W-1:0] : cnt_q;
      carry_q <= carry_q || (add_one && cnt_sum[`DBIS_CNT_W]);
      acc_q <= at_tp2 ? acc_q + 1'b1 : acc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word interlock, alarm and word register

  logic alarm_q;
  wire logic ilock_set;
  wire logic overrun;

  assign ilock_set = (at_tp2 && !carry_q) || si_d.prep_read;
  assign overrun = arrive && !ilock_q;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ilock_q <= 1'b0;
      alarm_q <= 1'b0;
      io_word_register_q <= '0;
    end else begin
      ilock_q <= ilock_set || (ilock_q && !arrive);
      alarm_q <= overrun || (alarm_q && !at_tp2);
      io_word_register_q <= arrive ? DRUM_WORD : io_word_register_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage write path

  dbis_pkg::dbis_es_write_t wr_in;
  dbis_pkg::dbis_es_write_t wr_out;

  assign wr_in.addr = acc_q;
  assign wr_in.data = io_word_register_q;

  dbis_fifo #(
    .WIDTH($bits(dbis_pkg::dbis_es_write_t)),
    .DEPTH(`DBIS_FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_n(rst_n_q),
    .in_valid(at_tp2),
    .in_ready(fifo_in_ready),
    .in_data(wr_in),
    .out_valid(ES_WR_VALID),
    .out_ready(ES_WR_READY),
    .out_data(wr_out)
  );

  assign ES_WR_ADDR = wr_out.addr;
  assign ES_WR_DATA = wr_out.data;

  ////////////////////////////////////////////////////////////////////////////
  // status outputs

  logic req_q;
  logic done_q;
  logic busy_q;
  logic stopped_q;
  logic restore_q;
  logic [3:0] tp_q;
  logic [3:0] tp_num;

  always_comb begin
    unique case (nxt)
      dbis_pkg::ST_TP1: tp_num = 4'h1;
      dbis_pkg::ST_TP2: tp_num = 4'h2;
      dbis_pkg::ST_TP3: tp_num = 4'h3;
      dbis_pkg::ST_TP4: tp_num = 4'h4;
      dbis_pkg::ST_TP5: tp_num = 4'h5;
      dbis_pkg::ST_TP6: tp_num = 4'h6;
      dbis_pkg::ST_TP7: tp_num = 4'h7;
      dbis_pkg::ST_TP8: tp_num = 4'h8;
      default: tp_num = 4'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      req_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      stopped_q <= 1'b0;
      restore_q <= 1'b1;
      tp_q <= 4'h0;
    end else begin
      req_q <= at_tp2 && !carry_q;
      done_q <= finish;
      busy_q <= (nxt != dbis_pkg::ST_IDLE);
      stopped_q <= (nxt != dbis_pkg::ST_IDLE) && !go;
      // restoration is only harmless while idle or stopped at pulse four or six
      restore_q <= (nxt == dbis_pkg::ST_IDLE) ||
                   (!go && (nxt == dbis_pkg::ST_TP4 || nxt == dbis_pkg::ST_TP6));
      tp_q <= go ? tp_num : tp_q;
    end
  end

  assign REQUEST_NEXT_WORD = req_q;
  assign DONE = done_q;
  assign BUSY = busy_q;
  assign CLOCK_STOPPED = stopped_q;
  assign RESTORE_OK = restore_q;
  assign TIME_PULSE = tp_q;
  assign ACC = acc_q;
  assign ALARM = alarm_q;

endmodule
`default_nettype wire

// ===== tb/dbis_block_input_sva.sv
// assertion checker for the drum block-input sequencer ports
`timescale 1ns/1ps
`default_nettype none
module dbis_block_input_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SI_STROBE,
  input wire logic [8:0] SI_CODE,
  input wire logic WORD_ARRIVED,
  input wire logic REQUEST_NEXT_WORD,
  input wire logic PREP_READ,
  input wire logic PREP_RECORD,
  input wire logic CHANGE_GROUP,
  input wire logic CHANGE_POSITION,
  input wire logic DRUM_ADDR_RESET,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic FAST_CARRY,
  input wire logic [3:0] TIME_PULSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic [3:0] tp_q;
  logic [11:0] cnt_q;
  wire logic si_hit = SI_STROBE && SI_CODE[8:3] == 6'h38;
  wire logic tp_chg = TIME_PULSE != tp_q;
  // cnt_q holds how long the previous time pulse lasted at the change
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tp_q <= 4'h0;
      cnt_q <= 12'h000;
    end else begin
      tp_q <= TIME_PULSE;
      // saturates so a long stall cannot wrap back below a bound
      cnt_q <= tp_chg ? 12'h001 : (&cnt_q ? cnt_q : cnt_q + 12'h001);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_si_read;
    si_hit && !SI_CODE[2];
  endsequence
  sequence s_leave(logic [3:0] a, logic [3:0] b);
    tp_q == a && TIME_PULSE == b;
  endsequence
  property p_si_read; s_si_read |=> PREP_READ && !PREP_RECORD; endproperty
  a_si_read: assert property (p_si_read) else $error("read code gave wrong prepare");
  property p_si_rec; si_hit && SI_CODE[2] |=> PREP_RECORD && !PREP_READ; endproperty
  a_si_rec: assert property (p_si_rec) else $error("record code gave wrong prepare");
  property p_si_bits;
    si_hit |=> CHANGE_POSITION == $past(SI_CODE[0]) && CHANGE_GROUP == $past(SI_CODE[1]);
  endproperty
  a_si_bits: assert property (p_si_bits) else $error("group or position change wrong");
  property p_addr_rst; s_si_read |=> DRUM_ADDR_RESET == $past(SI_CODE[0]); endproperty
  a_addr_rst: assert property (p_addr_rst) else $error("drum address reset wrong");
  property p_req; REQUEST_NEXT_WORD |-> BUSY ##1 !REQUEST_NEXT_WORD; endproperty
  a_req: assert property (p_req) else $error("word request outside order or too long");
  property p_done; DONE |-> ##[0:1] !BUSY; endproperty
  a_done: assert property (p_done) else $error("order still busy after done");
  property p_wr_hold; s_leave(4'h2, 4'h3) |-> cnt_q inside {[12'h739:12'h73d]}; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write hold wrong length");
  property p_tp3; s_leave(4'h3, 4'h4) |-> cnt_q inside {[12'h031:12'h035]}; endproperty
  a_tp3: assert property (p_tp3) else $error("pulse three to four spacing wrong");
  property p_rd_hold; s_leave(4'h4, 4'h5) |-> cnt_q >= 12'h351; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read stop too short");
  property p_carry; s_leave(4'h1, 4'h2) ##0 !FAST_CARRY |-> cnt_q >= 12'h063; endproperty
  a_carry: assert property (p_carry) else $error("end carry wait too short");
  property p_first; s_leave(4'h7, 4'h8) |-> cnt_q inside {[12'h031:12'h035]}; endproperty
  a_first: assert property (p_first) else $error("first cycle stop delay wrong");
  property p_wake;
    TIME_PULSE == 4'h6 && BUSY && cnt_q > 12'h35c && WORD_ARRIVED |-> ##[1:150] TIME_PULSE == 4'h7;
  endproperty
  a_wake: assert property (p_wake) else $error("no restart after word arrival");
endmodule
`default_nettype wire

// ===== tb/dbis_drum_model.sv
// behavioural drum read side: word arrivals paced by requests
`timescale 1ns/1ps
`default_nettype none
module dbis_drum_model #(
  parameter int SPACING = 3200
) (
  input wire logic clk,
  input wire logic arm,
  input wire logic [15:0] first_dly,
  input wire logic request,
  output logic arrived,
  output logic [15:0] word
);
  int wait_c = 0;
  int since = 0;
  int hold = 0;
  logic [15:0] k = 16'h0000;
  wire logic fire = !arm && !request && wait_c == 1;
  initial begin
    arrived = 1'b0;
    word = 16'h0000;
  end
  always @(posedge clk) begin
    arrived <= fire;
    since <= fire ? 1 : since + 1;
    hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
    // word held past the sync window, then the line toggles so no stale value
    word <= fire ? k : (hold > 0 ? word : ~word);
    if (arm) begin
      k <= 16'ha500;
      wait_c <= first_dly;
    end else if (request) begin
      wait_c <= since < SPACING ? SPACING - since : 1;
    end else if (fire) begin
      k <= k + 16'h0001;
      wait_c <= 0;
    end else if (wait_c > 1) begin
      wait_c <= wait_c - 1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/dbis_block_input_bench.sv
// self-checking bench for the drum block-input sequencer
`timescale 1ns/1ps
`default_nettype none
module dbis_block_input_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic [10:0] start_addr = 11'h000;
  logic [10:0] block_count = 11'h000;
  logic fast_carry = 1'b0;
  logic si_strobe = 1'b0;
  logic [8:0] si_code = 9'h000;
  logic es_wr_ready = 1'b1;
  logic arm = 1'b0;
  logic [15:0] first_dly = 16'h0064;
  wire logic word_arrived, req, p_rd, p_rec, c_grp, c_pos, a_rst, wr_valid, busy, done, stopped, alarm, rst_ok;
  wire logic [15:0] drum_word, wr_data;
  wire logic [10:0] wr_addr, acc;
  wire logic [3:0] tp;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_req = 0;
  int t_first = 0;
  int t_req = 0;
  logic [10:0] wa[$];
  logic [15:0] wd[$];
  always #10 clk = ~clk;
  dbis_block_input u_dut (.CLK(clk), .ARST_N(arst_n), .START(start), .START_ADDR(start_addr),
    .BLOCK_COUNT(block_count), .FAST_CARRY(fast_carry), .SI_STROBE(si_strobe), .SI_CODE(si_code),
    .WORD_ARRIVED(word_arrived), .DRUM_WORD(drum_word), .REQUEST_NEXT_WORD(req), .PREP_READ(p_rd),
    .PREP_RECORD(p_rec), .CHANGE_GROUP(c_grp), .CHANGE_POSITION(c_pos), .DRUM_ADDR_RESET(a_rst),
    .ES_WR_VALID(wr_valid), .ES_WR_READY(es_wr_ready), .ES_WR_ADDR(wr_addr), .ES_WR_DATA(wr_data),
    .BUSY(busy), .DONE(done), .ACC(acc), .TIME_PULSE(tp), .CLOCK_STOPPED(stopped), .ALARM(alarm),
    .RESTORE_OK(rst_ok));
  dbis_drum_model u_drum (.clk(clk), .arm(arm), .first_dly(first_dly), .request(req),
    .arrived(word_arrived), .word(drum_word));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_valid && es_wr_ready) begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end
    if (req) n_req <= n_req + 1;
    if (req && n_req == 0) t_req <= cyc;
    if (word_arrived && t_first == 0) t_first <= cyc;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_si(input logic [8:0] code);
    @(posedge clk);
    si_strobe <= 1'b1;
    si_code <= code;
    @(posedge clk);
    si_strobe <= 1'b0;
    @(negedge clk);
  endtask
  // every drum code plus one foreign code that must stay silent
  task automatic t_select;
    logic [8:0] c;
    logic hit;
    for (int i = 0; i < 9; i++) begin
      c = i < 8 ? 9'h1c0 + i[8:0] : 9'h0c3;
      hit = c[8:3] == 6'h38;
      do_si(c);
      check("prep_read", p_rd, hit && !c[2]);
      check("prep_record", p_rec, hit && c[2]);
      check("chg_pos", c_pos, hit && c[0]);
      check("chg_group", c_grp, hit && c[1]);
      check("addr_reset", a_rst, hit && !c[2] && c[0]);
    end
  endtask
  task automatic t_block(input int n, input logic [15:0] dly, input int stall);
    int i;
    int t0;
    wa.delete();
    wd.delete();
    n_req = 0;
    t_first = 0;
    do_si(9'h1c0);
    @(posedge clk);
    arm <= 1'b1;
    first_dly <= dly;
    start <= 1'b1;
    start_addr <= 11'h100;
    block_count <= 11'h7ff - n[10:0];
    es_wr_ready <= stall == 0;
    @(posedge clk);
    arm <= 1'b0;
    start <= 1'b0;
    for (i = 0; i < stall; i++) @(posedge clk);
    if (stall > 0) begin
      @(negedge clk);
      check("fifo holds", wr_valid, 1'b1);
      check("tp stalls", tp, 4'h1);
      check("stall stopped", stopped, 1'b1);
      @(posedge clk);
    end
    es_wr_ready <= 1'b1;
    for (i = 0; i < (n + 2) * 4000 && done !== 1'b1; i++) begin
      @(negedge clk);
      if (i == 1500 && dly > 16'h0640) begin
        check("tp waits", tp, 4'h6);
        check("stopped", stopped, 1'b1);
        check("restore parked", rst_ok, 1'b1);
      end
    end
    t0 = cyc;
    check("done", done, 1'b1);
    for (i = 0; i < 20 && wr_valid !== 1'b0; i++) @(negedge clk);
    check("writes", wa.size(), n);
    foreach (wa[j]) begin
      check("addr", wa[j], 11'h100 + j[10:0]);
      check("data", wd[j], 16'ha500 + j[15:0]);
    end
    check("acc", acc, 11'h100 + n[10:0]);
    check("requests", n_req, n > 0 ? n - 1 : 0);
    if (stall == 0 && n > 0) check("span", t0 - t_first <= (64 * n + 37) * 50, 1'b1);
    if (dly > 16'h0384 && n > 1) check("req lag", t_req - t_first <= 500, 1'b1);
    check("alarm", alarm, 1'b0);
  endtask
  // a word landing with the interlock already clear must raise the alarm
  task automatic t_overrun;
    @(posedge clk);
    arm <= 1'b1;
    first_dly <= 16'h0010;
    @(posedge clk);
    arm <= 1'b0;
    repeat (30) @(negedge clk);
    check("alarm set", alarm, 1'b1);
    check("idle", busy, 1'b0);
  endtask
  initial begin
    #(20 * 90000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("restore_ok", rst_ok, 1'b1);
    t_select();
    t_block(1, 16'h0064, 0);
    t_block(3, 16'h07d0, 0);
    t_block(0, 16'h0064, 0);
    t_overrun();
    @(posedge clk) fast_carry <= 1'b1;
    t_block(2, 16'h0064, 0);
    @(posedge clk) fast_carry <= 1'b0;
    t_block(5, 16'h0064, 16000);
    finish_test();
  end
endmodule
bind dbis_block_input dbis_block_input_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .SI_STROBE(SI_STROBE),
  .SI_CODE(SI_CODE), .WORD_ARRIVED(WORD_ARRIVED), .REQUEST_NEXT_WORD(REQUEST_NEXT_WORD),
  .PREP_READ(PREP_READ), .PREP_RECORD(PREP_RECORD), .CHANGE_GROUP(CHANGE_GROUP),
  .CHANGE_POSITION(CHANGE_POSITION), .DRUM_ADDR_RESET(DRUM_ADDR_RESET), .BUSY(BUSY), .DONE(DONE),
  .FAST_CARRY(FAST_CARRY), .TIME_PULSE(TIME_PULSE));
`default_nettype wire
